// File: design/jdc_pkg.sv
`default_nettype none
package jdc_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0]  CFG_ONE_INDEX = 8'h1A;
  localparam logic [7:0]  CFG_TWO_INDEX = 8'h1B;
  localparam logic [31:0] CFG_ONE_ADDR  = {22'h0, CFG_ONE_INDEX, 2'h0};
  localparam logic [31:0] CFG_TWO_ADDR  = {22'h0, CFG_TWO_INDEX, 2'h0};

  localparam logic [7:0]  CFG_ONE_RESET = 8'h00;
  localparam logic [7:0]  CFG_TWO_RESET = 8'h00;
  // writable bits; reserved bits stay zero
  localparam logic [7:0]  CFG_ONE_WMASK = 8'h7E;
  localparam logic [7:0]  CFG_TWO_WMASK = 8'h7F;

  // field positions in the first register
  localparam int POS_RESERVED_LO   = 0;
  localparam int POS_DETECTOR_ON   = 1;
  localparam int POS_DOUBLE_CURR   = 2;
  localparam int POS_COUPLING      = 3;
  localparam int POS_INSERT_LO     = 4;
  localparam int POS_INSERT_HI     = 5;
  localparam int POS_PAIR_SELECT   = 6;
  localparam int POS_RESERVED_HI   = 7;

  localparam logic [1:0]  HTRANS_IDLE   = 2'h0;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic        HRESP_OKAY    = 1'h0;
  localparam logic [23:0] RDATA_PAD     = 24'h000000;

  // impedance figures in ohms
  localparam logic [15:0] OHM_NONE = 16'h0000;
  localparam logic [15:0] OHM_50   = 16'h0032;
  localparam logic [15:0] OHM_100  = 16'h0064;
  localparam logic [15:0] OHM_150  = 16'h0096;
  localparam logic [15:0] OHM_320  = 16'h0140;
  localparam logic [15:0] OHM_680  = 16'h02A8;
  localparam logic [15:0] OHM_800  = 16'h0320;
  localparam logic [15:0] OHM_1350 = 16'h0546;
  localparam logic [15:0] OHM_1750 = 16'h06D6;

  localparam logic [1:0]  INSERT_CODE_150 = 2'h0;
  localparam logic [1:0]  INSERT_CODE_100 = 2'h1;
  localparam logic [1:0]  INSERT_CODE_50  = 2'h2;
  localparam logic [1:0]  INSERT_CODE_RSV = 2'h3;

  typedef struct packed {
    logic       reserved_hi;
    logic       hook_threshold_pair_select;
    logic [1:0] hook_insert_min_impedance;
    logic       headphone_coupling_select;
    logic       double_detect_current;
    logic       headset_detector_on;
    logic       reserved_lo;
  } jdc_cfg_one_type;

  typedef struct packed {
    logic [15:0] mic_min_ohm;
    logic [15:0] hook_max_ohm;
    logic [15:0] hook_insert_ohm;
    logic        hook_insert_valid;
  } jdc_thresh_type;

  typedef struct packed {
    logic valid;
    logic write;
    logic sel_one;
    logic sel_two;
  } jdc_dphase_type;

endpackage
`default_nettype wire

// File: design/jdc_threshold_decode.sv
`timescale 1ns/100ps
`default_nettype none
module jdc_threshold_decode
  import jdc_pkg::*;
(
  input  wire logic            hclk,
  input  wire logic            hresetn,
  input  wire jdc_cfg_one_type cfg,
  input  wire logic            external_resistor_type_bit,
  output var  jdc_thresh_type  thresholds
);

  jdc_thresh_type thr_d;
  jdc_thresh_type thr_q;

  always_comb begin
    thr_d = '0;
    if (!cfg.hook_threshold_pair_select) begin
      thr_d.mic_min_ohm  = OHM_800;
      thr_d.hook_max_ohm = cfg.headphone_coupling_select ? OHM_150 : OHM_320;
    end else begin
      thr_d.hook_max_ohm = OHM_680;
      thr_d.mic_min_ohm  = cfg.headphone_coupling_select ? OHM_1750 : OHM_1350;
    end
    // reserved code and external resistor type both leave insertion unsupported
    thr_d.hook_insert_valid = !external_resistor_type_bit;
    unique case (cfg.hook_insert_min_impedance)
      INSERT_CODE_150: thr_d.hook_insert_ohm = OHM_150;
      INSERT_CODE_100: thr_d.hook_insert_ohm = OHM_100;
      INSERT_CODE_50:  thr_d.hook_insert_ohm = OHM_50;
      INSERT_CODE_RSV: begin
        thr_d.hook_insert_ohm   = OHM_NONE;
        thr_d.hook_insert_valid = 1'b0;
      end
    endcase
    if (!thr_d.hook_insert_valid) begin
      thr_d.hook_insert_ohm = OHM_NONE;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      thr_q <= '0;
    end else begin
      thr_q <= thr_d;
    end
  end

  assign thresholds = thr_q;

endmodule
`default_nettype wire

// File: design/jdc_config_regs.sv
// The AHB-Lite register port was decided locally.
`timescale 1ns/100ps
`default_nettype none
module jdc_config_regs
  import jdc_pkg::*;
(
  input  wire logic           hclk,
  input  wire logic           hresetn,
  input  wire logic           hsel,
  input  wire logic [31:0]    haddr,
  input  wire logic [1:0]     htrans,
  input  wire logic           hwrite,
  input  wire logic [2:0]     hsize,
  input  wire logic [31:0]    hwdata,
  input  wire logic           hready,
  output logic                hreadyout,
  output logic [31:0]         hrdata,
  output logic                hresp,
  input  wire logic           external_resistor_type_bit,
  output logic                headset_detector_on,
  output logic                headphone_coupling_select,
  output logic                double_detect_current,
  output logic                hook_threshold_pair_select,
  output logic [1:0]          hook_insert_min_impedance,
  output var  jdc_thresh_type thresholds,
  output logic [7:0]          config_two_value
);

  jdc_cfg_one_type cfg_one_q;
  jdc_cfg_one_type cfg_one_d;
  logic [7:0]      cfg_two_q;
  logic [7:0]      cfg_two_d;
  jdc_dphase_type  dph_q;
  jdc_dphase_type  dph_d;
  logic [31:0]     rdata_q;
  logic [31:0]     rdata_d;
  logic            readyout_q;
  logic            resp_q;
  logic            addr_phase;
  logic            wr_one;
  logic            wr_two;

  // only word transfers are expected; size does not alter the decode
  assign addr_phase = hsel && hready && htrans[1];

  always_comb begin
    dph_d         = '0;
    dph_d.valid   = addr_phase;
    dph_d.write   = addr_phase && hwrite;
    dph_d.sel_one = addr_phase && (haddr == CFG_ONE_ADDR);
    dph_d.sel_two = addr_phase && (haddr == CFG_TWO_ADDR);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_q <= '0;
    end else begin
      dph_q <= dph_d;
    end
  end

  // zero wait states, so every data phase ends on the next edge
  assign wr_one = dph_q.valid && dph_q.write && dph_q.sel_one;
  assign wr_two = dph_q.valid && dph_q.write && dph_q.sel_two;

  always_comb begin
    cfg_one_d = cfg_one_q;
    cfg_two_d = cfg_two_q;
    if (wr_one) begin
      cfg_one_d = jdc_cfg_one_type'(hwdata[7:0] & CFG_ONE_WMASK);
    end
    if (wr_two) begin
      cfg_two_d = hwdata[7:0] & CFG_TWO_WMASK;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_one_q <= jdc_cfg_one_type'(CFG_ONE_RESET);
    end else begin
      cfg_one_q <= cfg_one_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_two_q <= CFG_TWO_RESET;
    end else begin
      cfg_two_q <= cfg_two_d;
    end
  end

  // read from next value so a read right behind a write sees the new data
  always_comb begin
    rdata_d = '0;
    if (addr_phase && !hwrite) begin
      if (haddr == CFG_ONE_ADDR) begin
        rdata_d = {RDATA_PAD, cfg_one_d};
      end else if (haddr == CFG_TWO_ADDR) begin
        rdata_d = {RDATA_PAD, cfg_two_d};
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      readyout_q <= 1'b1;
      resp_q     <= HRESP_OKAY;
    end else begin
      readyout_q <= 1'b1;
      resp_q     <= HRESP_OKAY;
    end
  end

  assign hreadyout = readyout_q;
  assign hresp     = resp_q;
  assign hrdata    = rdata_q;

  assign headset_detector_on        = cfg_one_q.headset_detector_on;
  assign headphone_coupling_select  = cfg_one_q.headphone_coupling_select;
  assign double_detect_current      = cfg_one_q.double_detect_current;
  assign hook_threshold_pair_select = cfg_one_q.hook_threshold_pair_select;
  assign hook_insert_min_impedance  = cfg_one_q.hook_insert_min_impedance;
  assign config_two_value           = cfg_two_q;

  // decoded thresholds lag the register by one edge
  jdc_threshold_decode u_decode (
    .hclk                       (hclk),
    .hresetn                    (hresetn),
    .cfg                        (cfg_one_q),
    .external_resistor_type_bit (external_resistor_type_bit),
    .thresholds                 (thresholds)
  );

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_write_one;
    addr_phase && hwrite && (haddr == CFG_ONE_ADDR) ##1 1'b1;
  endsequence

  sequence s_write_two;
    addr_phase && hwrite && (haddr == CFG_TWO_ADDR) ##1 1'b1;
  endsequence

  sequence s_read_one;
    addr_phase && !hwrite && (haddr == CFG_ONE_ADDR);
  endsequence

  sequence s_read_other;
    addr_phase && !hwrite && (haddr != CFG_ONE_ADDR) && (haddr != CFG_TWO_ADDR);
  endsequence

  sequence s_read_two;
    addr_phase && !hwrite && (haddr == CFG_TWO_ADDR);
  endsequence

  sequence s_write_other;
    addr_phase && hwrite && (haddr != CFG_ONE_ADDR) && (haddr != CFG_TWO_ADDR) ##1 1'b1;
  endsequence

  a_reset_one_clear: assert property (
    $rose(hresetn) |-> (cfg_one_q == jdc_cfg_one_type'(CFG_ONE_RESET)) && !headset_detector_on)
    else $error("first register not zero after reset");

  a_reset_two_clear: assert property (
    $rose(hresetn) |-> (config_two_value == CFG_TWO_RESET))
    else $error("second register not zero after reset");

  a_write_one_lands: assert property (
    s_write_one |=> (cfg_one_q == jdc_cfg_one_type'($past(hwdata[7:0]) & CFG_ONE_WMASK)))
    else $error("write to first register not stored");

  a_write_two_lands: assert property (
    s_write_two |=> (config_two_value == ($past(hwdata[7:0]) & CFG_TWO_WMASK)))
    else $error("write to second register not stored");

  a_detector_on_follows: assert property (
    s_write_one |=> (headset_detector_on == $past(hwdata[POS_DETECTOR_ON])))
    else $error("detector enable does not follow write");

  a_coupling_follows: assert property (
    s_write_one |=> (headphone_coupling_select == $past(hwdata[POS_COUPLING])))
    else $error("coupling select does not follow write");

  a_double_curr_follows: assert property (
    s_write_one |=> (double_detect_current == $past(hwdata[POS_DOUBLE_CURR])))
    else $error("double current does not follow write");

  a_reset_outputs_zero: assert property (
    $rose(hresetn) |-> (hrdata == '0) && (thresholds == '0) && !hook_threshold_pair_select
    && (hook_insert_min_impedance == '0) && !double_detect_current && !headphone_coupling_select)
    else $error("outputs not cleared by reset");

  a_pair_follows: assert property (
    s_write_one |=> (hook_threshold_pair_select == $past(hwdata[POS_PAIR_SELECT])))
    else $error("pair select does not follow write");

  a_insert_field_follows: assert property (
    s_write_one |=> (hook_insert_min_impedance == $past(hwdata[POS_INSERT_HI:POS_INSERT_LO])))
    else $error("insertion code does not follow write");

  a_read_one_back: assert property (
    s_read_one |=> (hrdata == {RDATA_PAD, cfg_one_q}) && hreadyout)
    else $error("first register read data wrong");

  a_read_two_back: assert property (
    s_read_two |=> (hrdata == {RDATA_PAD, config_two_value}) && hreadyout)
    else $error("second register read data wrong");

  a_reserved_read_zero: assert property (
    s_read_one |=> !hrdata[POS_RESERVED_HI] && !hrdata[POS_RESERVED_LO])
    else $error("reserved bit reads nonzero");

  // register two keeps its top bit reserved as well
  a_reserved_store_zero: assert property (
    !cfg_one_q.reserved_hi && !cfg_one_q.reserved_lo && !config_two_value[POS_RESERVED_HI])
    else $error("reserved bit stored nonzero");

  a_unmapped_zero: assert property (
    s_read_other |=> (hrdata == '0) && (hresp == HRESP_OKAY))
    else $error("unmapped read not zero");

  a_unmapped_write_dropped: assert property (
    s_write_other |=> $stable(cfg_one_q) && $stable(config_two_value))
    else $error("unmapped write changed a register");

  a_rdata_idle_zero: assert property (
    !(addr_phase && !hwrite) |=> (hrdata == '0))
    else $error("read data not zero outside a read");

  a_bus_always_ready: assert property (
    hreadyout && (hresp == HRESP_OKAY))
    else $error("bus stalled or error response");

  a_idle_hold: assert property (
    !$past(addr_phase && hwrite) |=> $stable(cfg_one_q) && $stable(config_two_value))
    else $error("register changed without a write");

  // thresholds trail the register by one edge, so the edge after reset is skipped
  a_pair_zero_hook: assert property (
    $past(hresetn) && !$past(cfg_one_q.hook_threshold_pair_select) |->
    (thresholds.mic_min_ohm == OHM_800) && (thresholds.hook_max_ohm ==
    ($past(cfg_one_q.headphone_coupling_select) ? OHM_150 : OHM_320)))
    else $error("pair zero thresholds wrong");

  a_pair_one_mic: assert property (
    $past(hresetn) && $past(cfg_one_q.hook_threshold_pair_select) |->
    (thresholds.hook_max_ohm == OHM_680) && (thresholds.mic_min_ohm ==
    ($past(cfg_one_q.headphone_coupling_select) ? OHM_1750 : OHM_1350)))
    else $error("pair one thresholds wrong");

  a_insert_ignored: assert property (
    $past(hresetn) && ($past(external_resistor_type_bit)
    || ($past(cfg_one_q.hook_insert_min_impedance) == INSERT_CODE_RSV))
    |-> !thresholds.hook_insert_valid && (thresholds.hook_insert_ohm == OHM_NONE))
    else $error("insertion threshold not ignored");

  a_insert_code_fifty: assert property (
    $past(hresetn) && !$past(external_resistor_type_bit)
    && ($past(cfg_one_q.hook_insert_min_impedance) == INSERT_CODE_50)
    |-> thresholds.hook_insert_valid && (thresholds.hook_insert_ohm == OHM_50))
    else $error("insertion code two not fifty ohm");

  a_insert_code_hundred: assert property (
    $past(hresetn) && !$past(external_resistor_type_bit)
    && ($past(cfg_one_q.hook_insert_min_impedance) == INSERT_CODE_100)
    |-> thresholds.hook_insert_valid && (thresholds.hook_insert_ohm == OHM_100))
    else $error("insertion code one not hundred ohm");

  a_insert_code_default: assert property (
    $past(hresetn) && !$past(external_resistor_type_bit)
    && ($past(cfg_one_q.hook_insert_min_impedance) == INSERT_CODE_150)
    |-> thresholds.hook_insert_valid && (thresholds.hook_insert_ohm == OHM_150))
    else $error("insertion code zero not hundred fifty ohm");

  a_thresh_stable: assert property (
    $past(hresetn) && $stable(cfg_one_q) && $stable(external_resistor_type_bit)
    |=> $stable(thresholds))
    else $error("thresholds moved without a cause");

endmodule
`default_nettype wire

// File: sim/jack_detect_config_regs_bench.sv
`timescale 1ns/100ps
`default_nettype none
module jack_detect_config_regs_bench
  import jdc_pkg::*;
;
  logic           hclk;
  logic           hresetn;
  logic           hsel;
  logic [31:0]    haddr;
  logic [1:0]     htrans;
  logic           hwrite;
  logic [2:0]     hsize;
  logic [31:0]    hwdata;
  logic           hreadyout;
  logic [31:0]    hrdata;
  logic           hresp;
  logic           ext_bit;
  logic           det_on;
  logic           coupling;
  logic           dbl;
  logic           pair;
  logic [1:0]     ins;
  jdc_thresh_type thr;
  logic [7:0]     cfg_two;
  int             error_cnt;
  int             checks;

  jdc_config_regs dut (
    .hclk                       (hclk),
    .hresetn                    (hresetn),
    .hsel                       (hsel),
    .haddr                      (haddr),
    .htrans                     (htrans),
    .hwrite                     (hwrite),
    .hsize                      (hsize),
    .hwdata                     (hwdata),
    .hready                     (hreadyout),
    .hreadyout                  (hreadyout),
    .hrdata                     (hrdata),
    .hresp                      (hresp),
    .external_resistor_type_bit (ext_bit),
    .headset_detector_on        (det_on),
    .headphone_coupling_select  (coupling),
    .double_detect_current      (dbl),
    .hook_threshold_pair_select (pair),
    .hook_insert_min_impedance  (ins),
    .thresholds                 (thr),
    .config_two_value           (cfg_two)
  );

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  task automatic final_report();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // bounded wait; slave is zero-wait but never trust that
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      error_cnt++;
      $display("MISMATCH hready expected 1 seen %b", hreadyout);
      final_report();
    end
  endtask

  // entered and left at a rising edge, so calls run back to back
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'h2;
    wait_ready();
    hsel <= 1'b0;
    htrans <= HTRANS_IDLE;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
    chk("hresp", {31'h0, HRESP_OKAY}, {31'h0, hresp});
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rd_chk(input string name, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(name, exp, x);
  endtask

  task automatic t_reset();
    rd_chk("one reset", CFG_ONE_ADDR, 32'h0);
    rd_chk("two reset", CFG_TWO_ADDR, 32'h0);
    chk("outs reset", 32'h0, {18'h0, cfg_two, det_on, coupling, dbl, pair, ins});
    chk("mic reset", {16'h0, OHM_800}, {16'h0, thr.mic_min_ohm});
    chk("hook reset", {16'h0, OHM_320}, {16'h0, thr.hook_max_ohm});
    chk("ins reset", {15'h0, OHM_150, 1'b1}, {15'h0, thr.hook_insert_ohm, thr.hook_insert_valid});
  endtask

  // walk a single one across every bit, then all ones
  task automatic t_fields();
    logic [7:0] v;
    for (int i = 0; i <= 8; i++) begin
      v = (i == 8) ? 8'hFF : 8'h01 << i;
      wr(CFG_ONE_ADDR, {24'h0, v});
      @(negedge hclk);
      chk("det_on", {31'h0, v[1]}, {31'h0, det_on});
      chk("dbl", {31'h0, v[2]}, {31'h0, dbl});
      chk("coupling", {31'h0, v[3]}, {31'h0, coupling});
      chk("ins", {30'h0, v[5:4]}, {30'h0, ins});
      chk("pair", {31'h0, v[6]}, {31'h0, pair});
      @(posedge hclk);
      rd_chk("one rb", CFG_ONE_ADDR, {24'h0, v & 8'h7E});
    end
  endtask

  task automatic t_thresh();
    logic [15:0] m;
    logic [15:0] h;
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 2; c++) begin
        wr(CFG_ONE_ADDR, {24'h0, 1'b0, p[0], 2'h0, c[0], 3'h0});
        m = p ? (c ? OHM_1750 : OHM_1350) : OHM_800;
        h = p ? OHM_680 : (c ? OHM_150 : OHM_320);
        @(posedge hclk);
        @(negedge hclk);
        chk("mic", {16'h0, m}, {16'h0, thr.mic_min_ohm});
        chk("hook", {16'h0, h}, {16'h0, thr.hook_max_ohm});
        @(posedge hclk);
      end
    end
  endtask

  task automatic t_insert();
    logic        ok;
    logic [15:0] o;
    for (int e = 0; e < 2; e++) begin
      for (int k = 0; k < 4; k++) begin
        ext_bit <= e[0];
        wr(CFG_ONE_ADDR, {26'h0, k[1:0], 4'h0});
        ok = (e == 0) && (k != 3);
        o = !ok ? OHM_NONE : (k == 0) ? OHM_150 : (k == 1) ? OHM_100 : OHM_50;
        @(posedge hclk);
        @(negedge hclk);
        chk("ins thr", {15'h0, o, ok}, {15'h0, thr.hook_insert_ohm, thr.hook_insert_valid});
        @(posedge hclk);
      end
    end
    ext_bit <= 1'b0;
  endtask

  task automatic t_two();
    wr(CFG_TWO_ADDR, 32'hFFFFFFFF);
    @(negedge hclk);
    chk("two out", 32'h7F, {24'h0, cfg_two});
    @(posedge hclk);
    rd_chk("two rb", CFG_TWO_ADDR, 32'h7F);
    // write then read back to back, then an unmapped slot
    wr(CFG_ONE_ADDR, 32'h42);
    rd_chk("one b2b", CFG_ONE_ADDR, 32'h42);
    wr(32'h70, 32'hFF);
    rd_chk("unmapped", 32'h70, 32'h0);
    rd_chk("one kept", CFG_ONE_ADDR, 32'h42);
    // reset in mid-run must clear both registers again
    hresetn <= 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd_chk("one rst2", CFG_ONE_ADDR, 32'h0);
    rd_chk("two rst2", CFG_TWO_ADDR, 32'h0);
    chk("outs rst2", 32'h0, {18'h0, cfg_two, det_on, coupling, dbl, pair, ins});
  endtask

  initial begin
    error_cnt = 0;
    checks = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = HTRANS_IDLE;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    ext_bit = 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_fields();
    t_thresh();
    t_insert();
    t_two();
    final_report();
  end
endmodule
`default_nettype wire
